// file: hdl/reg_access_ports.sv
// Serial register access front end: SPI slave and clause-45 management slave.
// Assumes one register space behind reg_* answering with reg_ack; both
// serial clocks are sampled by mclk, which must run far faster than them.
`include "reg_access_map.svh"

// Contract
// RULE1 - One access port at a time; no arbitration.
// RULE2 - Devices 1, 4, 7, 9, F and 1E group the registers.
// RULE3 - Management data rate at most 2.5 Mbps.
// RULE4 - Management port does address, write, read and read-increment.
// RULE5 - Four port addresses: three strap bits over two channel bits.
// RULE6 - Host writes the upper half first, then the lower.
// RULE7 - Never lower half first, never one half only.
// RULE8 - Read-increment at lower half gives 15:0; next read gives 31:16.
// RULE9 - Full read sequence per register; no chained increments.
// RULE10 - Wide register: two management addresses; SPI sees full words.
// RULE11 - SPI active only with select low; else MISO released.
// RULE12 - MOSI is sampled on every rising SCK edge.
// RULE13 - SPI instruction is 56 bits: command, 23 address, 32 data.
// RULE14 - Most significant bit first, 55 down to 0, both directions.
// RULE15 - Bit 55 command, 54:53 channel, 52:48 device, 47:32 register, 31:0 data.
// RULE16 - A write stores its 32-bit data in the addressed register.
// RULE17 - Master clocks all data bits on reads too; values ignored.
// RULE18 - Reads pipelined: previous read's data returns in the next.
// RULE19 - Undefined bits and unmapped addresses read as zero.
// RULE20 - Read after write shows the write data on MISO.
// RULE21 - Write after read shows all zeros in the MISO data field.
// RULE22 - Default timing moves MISO on falling SCK.
// RULE23 - Select high clears the bit counter and drops partial instructions.
module reg_access_ports (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        spi_sck,
  input  wire logic        spi_ssn_n,
  input  wire logic        spi_mosi,
  input  wire logic        spi_fast_mode,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic [2:0]  port_addr_strap,
  output logic             reg_req,
  output logic             reg_we,
  output logic [1:0]       reg_chan,
  output logic [4:0]       reg_dev,
  output logic [15:0]      reg_num,
  output logic [31:0]      reg_wdata,
  input  wire logic        reg_ack,
  input  wire logic        reg_hit,
  input  wire logic [31:0] reg_rdata
);

  function automatic logic dev_known(input logic [4:0] dev);
    dev_known = (dev == `DEV_LINE_PMA) || (dev == `DEV_RATE_COMP) ||
                (dev == `DEV_LINE_KR) || (dev == `DEV_HOST_PMA) ||
                (dev == `DEV_HOST_KR) || (dev == `DEV_GLOBAL);  // RULE2
  endfunction : dev_known

  // Pin synchronisers
  logic [`SY_WIDTH-1:0] pin_lvl;
  logic [`SY_WIDTH-1:0] pin_rise;
  logic [`SY_WIDTH-1:0] pin_fall;

  pin_sync #(
    .WIDTH   (`SY_WIDTH),
    .RST_VAL (`SY_RESET_VAL)
  ) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .din    ({port_addr_strap, spi_fast_mode, mdio_in, mdc, spi_mosi, spi_ssn_n, spi_sck}),
    .lvl    (pin_lvl),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  // SPI slave
  logic [5:0]  spi_cnt_ff;
  logic [55:0] spi_rx_ff;
  logic        spi_cmd_ff;
  logic        prev_cmd_ff;
  logic [22:0] prev_addr_ff;
  logic [31:0] prev_data_ff;
  logic        miso_ff;
  logic        miso_oe_ff;
  logic        sck_rise_d_ff;
  logic        pend_spi_ff;

  wire         ssn_low   = ~pin_lvl[`SY_SSN];                            // RULE11
  wire         sck_rise  = pin_rise[`SY_SCK] & ssn_low;                  // RULE12
  wire         sck_fall  = pin_fall[`SY_SCK] & ssn_low;
  wire [55:0]  spi_rx_nxt = {spi_rx_ff[54:0], pin_lvl[`SY_MOSI]};        // RULE14
  wire         spi_done  = sck_rise & (spi_cnt_ff == `SPI_LAST_BIT);     // RULE13
  wire         spi_is_wr = (spi_rx_nxt[`SPI_CMD_POS] == reg_access_pkg::SPI_CMD_WRITE);
  wire [4:0]   spi_dev   = spi_rx_nxt[`SPI_DEV_HI:`SPI_DEV_LO];          // RULE15
  wire         spi_go    = spi_done & dev_known(spi_dev);
  wire         spi_ack   = reg_ack & pend_spi_ff;

  // Transmit side: header of the previous instruction, then its data field
  wire [5:0]   spi_idx   = `SPI_LAST_BIT - spi_cnt_ff;                   // RULE14
  wire [5:0]   hdr_idx   = spi_idx - `SPI_DATA_BITS;
  wire [23:0]  spi_hdr   = {prev_cmd_ff, prev_addr_ff};
  wire         zero_data = spi_cmd_ff & ~prev_cmd_ff;                    // RULE21
  wire         data_bit  = ~zero_data & prev_data_ff[spi_idx[4:0]];      // RULE18 RULE20
  wire         spi_tx    = (spi_idx >= `SPI_DATA_BITS) ? spi_hdr[hdr_idx[4:0]] : data_bit;
  // Fast mode waits a cycle so the counter has moved
  wire         miso_upd  = pin_lvl[`SY_FAST] ? sck_rise_d_ff : sck_fall; // RULE22

  wire [5:0]   nxt_spi_cnt = !ssn_low ? 6'h00 :                          // RULE23
                             spi_done ? 6'h00 :
                             sck_rise ? spi_cnt_ff + 6'h01 : spi_cnt_ff;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      spi_cnt_ff    <= 6'h00;
      spi_rx_ff     <= '0;
      spi_cmd_ff    <= 1'b0;
      sck_rise_d_ff <= 1'b0;
    end else begin
      spi_cnt_ff    <= nxt_spi_cnt;
      sck_rise_d_ff <= sck_rise;
      if (sck_rise) begin
        spi_rx_ff <= spi_rx_nxt;                                         // RULE12
      end
      if (sck_rise && spi_cnt_ff == 6'h00) begin
        spi_cmd_ff <= pin_lvl[`SY_MOSI];
      end
    end
  end

  // Previous-instruction record that feeds MISO
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prev_cmd_ff  <= 1'b0;
      prev_addr_ff <= '0;
      prev_data_ff <= 32'h0000_0000;
    end else if (spi_done) begin
      prev_cmd_ff  <= spi_rx_nxt[`SPI_CMD_POS];
      prev_addr_ff <= spi_rx_nxt[`SPI_CHAN_HI:`SPI_REG_LO];
      // Write data echoes; a read clears until its fetch returns
      prev_data_ff <= spi_is_wr ? spi_rx_nxt[31:0] : 32'h0000_0000;     // RULE20 RULE19
    end else if (spi_ack) begin
      prev_data_ff <= reg_hit ? reg_rdata : 32'h0000_0000;              // RULE18 RULE19
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      miso_ff    <= 1'b0;
      miso_oe_ff <= 1'b0;
    end else begin
      miso_oe_ff <= ssn_low;                                             // RULE11
      if (pin_fall[`SY_SSN] || miso_upd) begin
        miso_ff <= spi_tx;                                               // RULE22
      end
    end
  end

  assign spi_miso    = miso_ff;
  assign spi_miso_oe = miso_oe_ff;

  // Management slave
  reg_access_pkg::mdio_state_t m_state_ff;
  reg_access_pkg::mdio_state_t nxt_m_state;
  logic [5:0]  m_cnt_ff;
  logic [5:0]  nxt_m_cnt;
  logic [15:0] m_sh_ff;
  logic [1:0]  m_op_ff;
  logic [1:0]  m_chan_ff;
  logic [4:0]  m_dev_ff;
  logic        m_match_ff;
  logic [15:0] m_addr_ff [4];
  logic [15:0] m_hi_wr_ff;
  logic [15:0] m_lo_rd_ff;
  logic [15:0] m_hi_rd_ff;
  logic [15:0] m_tx_ff;
  logic        mdio_out_ff;
  logic        mdio_oe_ff;
  logic        pend_mdio_ff;

  wire         mdc_rise  = pin_rise[`SY_MDC];                            // RULE3
  wire         mdio_bit  = pin_lvl[`SY_MDIO];
  wire [12:0]  hdr_nxt   = {m_sh_ff[11:0], mdio_bit};
  wire [15:0]  d_nxt     = {m_sh_ff[14:0], mdio_bit};
  wire [1:0]   hdr_op    = hdr_nxt[11:10];
  wire [1:0]   hdr_chan  = hdr_nxt[6:5];
  wire [4:0]   hdr_dev   = hdr_nxt[4:0];
  wire         hdr_match = ~hdr_nxt[12] & (hdr_nxt[9:7] == pin_lvl[`SY_PADDR_HI:`SY_PADDR_LO]); // RULE5
  wire         hdr_end   = mdc_rise & (m_state_ff == reg_access_pkg::MDIO_HDR) &
                           (m_cnt_ff == `MDIO_HDR_LAST);
  wire         ta_first  = mdc_rise & (m_state_ff == reg_access_pkg::MDIO_TA) &
                           (m_cnt_ff == 6'h00) & m_match_ff & m_op_ff[1];
  wire         ta_load   = mdc_rise & (m_state_ff == reg_access_pkg::MDIO_TA) &
                           (m_cnt_ff == `MDIO_TA_LAST) & m_match_ff & m_op_ff[1];
  wire         data_end  = mdc_rise & (m_state_ff == reg_access_pkg::MDIO_DATA) &
                           (m_cnt_ff == `MDIO_DATA_LAST) & m_match_ff;
  wire [15:0]  hdr_addr  = m_addr_ff[hdr_chan];
  wire [15:0]  cur_addr  = m_addr_ff[m_chan_ff];
  // Address bit 0 selects the half: 0 is bits 15:0, 1 is bits 31:16
  wire         rd_low    = hdr_end & hdr_match & hdr_op[1] & ~hdr_addr[0];        // RULE10
  wire         mdio_rd_go = rd_low & dev_known(hdr_dev);                          // RULE8
  wire         mdio_wr_go = data_end & (m_op_ff == `MDIO_OP_WRITE) & ~cur_addr[0] &
                            dev_known(m_dev_ff);                                   // RULE6 RULE7
  wire [15:0]  rd_word   = cur_addr[0] ? m_hi_rd_ff : m_lo_rd_ff;                 // RULE8 RULE9
  wire         mdio_ack  = reg_ack & pend_mdio_ff;

  always_comb begin
    nxt_m_state = m_state_ff;
    nxt_m_cnt   = m_cnt_ff;
    if (mdc_rise) begin
      case (m_state_ff)
        reg_access_pkg::MDIO_PRE: begin
          if (mdio_bit) begin
            nxt_m_cnt = (m_cnt_ff == `MDIO_PRE_MIN) ? m_cnt_ff : m_cnt_ff + 6'h01;
          end else begin
            if (m_cnt_ff == `MDIO_PRE_MIN) begin
              nxt_m_state = reg_access_pkg::MDIO_HDR;
            end
            nxt_m_cnt = 6'h00;
          end
        end
        reg_access_pkg::MDIO_HDR: begin
          if (m_cnt_ff == `MDIO_HDR_LAST) begin
            nxt_m_state = hdr_match ? reg_access_pkg::MDIO_TA : reg_access_pkg::MDIO_PRE;
            nxt_m_cnt   = 6'h00;
          end else begin
            nxt_m_cnt = m_cnt_ff + 6'h01;
          end
        end
        reg_access_pkg::MDIO_TA: begin
          if (m_cnt_ff == `MDIO_TA_LAST) begin
            nxt_m_state = reg_access_pkg::MDIO_DATA;
            nxt_m_cnt   = 6'h00;
          end else begin
            nxt_m_cnt = m_cnt_ff + 6'h01;
          end
        end
        reg_access_pkg::MDIO_DATA: begin
          if (m_cnt_ff == `MDIO_DATA_LAST) begin
            nxt_m_state = reg_access_pkg::MDIO_PRE;
            nxt_m_cnt   = 6'h00;
          end else begin
            nxt_m_cnt = m_cnt_ff + 6'h01;
          end
        end
        default: begin
          nxt_m_state = reg_access_pkg::MDIO_PRE;
          nxt_m_cnt   = 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      m_state_ff <= reg_access_pkg::MDIO_PRE;
      m_cnt_ff   <= 6'h00;
      m_sh_ff    <= 16'h0000;
      m_op_ff    <= `MDIO_OP_ADDR;
      m_chan_ff  <= 2'h0;
      m_dev_ff   <= 5'h00;
      m_match_ff <= 1'b0;
    end else begin
      m_state_ff <= nxt_m_state;
      m_cnt_ff   <= nxt_m_cnt;
      if (mdc_rise) begin
        m_sh_ff <= d_nxt;
      end
      if (hdr_end) begin
        m_op_ff    <= hdr_op;                                            // RULE4
        m_chan_ff  <= hdr_chan;
        m_dev_ff   <= hdr_dev;
        m_match_ff <= hdr_match;
      end
    end
  end

  // One address register per channel
  for (genvar c = 0; c < 4; c++) begin : g_addr
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        m_addr_ff[c] <= 16'h0000;
      end else if (data_end && m_chan_ff == 2'(c)) begin
        if (m_op_ff == `MDIO_OP_ADDR) begin
          m_addr_ff[c] <= d_nxt;                                         // RULE4
        end else if (m_op_ff == `MDIO_OP_RDINC) begin
          m_addr_ff[c] <= m_addr_ff[c] + 16'h0001;                       // RULE4 RULE8
        end
      end
    end
  end

  // Half-word staging for wide registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      m_hi_wr_ff <= 16'h0000;
      m_lo_rd_ff <= 16'h0000;
      m_hi_rd_ff <= 16'h0000;
    end else begin
      if (data_end && m_op_ff == `MDIO_OP_WRITE && cur_addr[0]) begin
        m_hi_wr_ff <= d_nxt;                                             // RULE6
      end
      if (rd_low && !dev_known(hdr_dev)) begin
        m_lo_rd_ff <= 16'h0000;                                          // RULE19
        m_hi_rd_ff <= 16'h0000;
      end else if (mdio_ack) begin
        m_lo_rd_ff <= reg_hit ? reg_rdata[15:0] : 16'h0000;              // RULE8 RULE19
        m_hi_rd_ff <= reg_hit ? reg_rdata[31:16] : 16'h0000;
      end
    end
  end

  // Read bits leave after a rising MDC; the host samples a period later
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      mdio_out_ff <= 1'b0;
      mdio_oe_ff  <= 1'b0;
      m_tx_ff     <= 16'h0000;
    end else if (ta_first) begin
      mdio_out_ff <= 1'b0;
      mdio_oe_ff  <= 1'b1;
    end else if (ta_load) begin
      mdio_out_ff <= rd_word[15];                                        // RULE8
      m_tx_ff     <= {rd_word[14:0], 1'b0};
    end else if (mdc_rise && m_state_ff == reg_access_pkg::MDIO_DATA && mdio_oe_ff) begin
      if (m_cnt_ff == `MDIO_DATA_LAST) begin
        mdio_oe_ff <= 1'b0;
      end else begin
        mdio_out_ff <= m_tx_ff[15];
        m_tx_ff     <= {m_tx_ff[14:0], 1'b0};
      end
    end
  end

  assign mdio_out = mdio_out_ff;
  assign mdio_oe  = mdio_oe_ff;

  // Shared register request
  logic        reg_req_ff;
  logic        reg_we_ff;
  logic [1:0]  reg_chan_ff;
  logic [4:0]  reg_dev_ff;
  logic [15:0] reg_num_ff;
  logic [31:0] reg_wdata_ff;

  // Ports never overlap, so SPI simply takes precedence
  wire         mdio_go     = mdio_rd_go | mdio_wr_go;                    // RULE1
  wire         nxt_req     = spi_go | mdio_go;
  wire         nxt_we      = spi_go ? spi_is_wr : mdio_wr_go;
  wire [1:0]   nxt_chan    = spi_go ? spi_rx_nxt[`SPI_CHAN_HI:`SPI_CHAN_LO] :
                             (mdio_rd_go ? hdr_chan : m_chan_ff);
  wire [4:0]   nxt_dev     = spi_go ? spi_dev : (mdio_rd_go ? hdr_dev : m_dev_ff);
  wire [15:0]  mdio_addr   = mdio_rd_go ? hdr_addr : cur_addr;
  wire [15:0]  nxt_num     = spi_go ? spi_rx_nxt[`SPI_REG_HI:`SPI_REG_LO] :
                             {1'b0, mdio_addr[15:1]};                    // RULE10
  wire [31:0]  nxt_wdata   = spi_go ? spi_rx_nxt[31:0] : {m_hi_wr_ff, d_nxt}; // RULE16 RULE7

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reg_req_ff   <= 1'b0;
      reg_we_ff    <= 1'b0;
      reg_chan_ff  <= 2'h0;
      reg_dev_ff   <= 5'h00;
      reg_num_ff   <= 16'h0000;
      reg_wdata_ff <= 32'h0000_0000;
      pend_spi_ff  <= 1'b0;
      pend_mdio_ff <= 1'b0;
    end else begin
      reg_req_ff <= nxt_req;
      if (nxt_req) begin
        reg_we_ff    <= nxt_we;                                          // RULE16
        reg_chan_ff  <= nxt_chan;
        reg_dev_ff   <= nxt_dev;
        reg_num_ff   <= nxt_num;
        reg_wdata_ff <= nxt_wdata;
      end
      // A new fetch wins over the acknowledge of an older one
      pend_spi_ff  <= (spi_go & ~spi_is_wr) | (pend_spi_ff & ~reg_ack);  // RULE18
      pend_mdio_ff <= mdio_rd_go | (pend_mdio_ff & ~reg_ack);
    end
  end

  assign reg_req   = reg_req_ff;
  assign reg_we    = reg_we_ff;
  assign reg_chan  = reg_chan_ff;
  assign reg_dev   = reg_dev_ff;
  assign reg_num   = reg_num_ff;
  assign reg_wdata = reg_wdata_ff;

endmodule : reg_access_ports

// file: hdl/reg_access_map.svh
// Offsets, field positions and cycle counts for the register access ports.
// Assumes inclusion by bare name from the design and verification files.
`ifndef REG_ACCESS_MAP_SVH
`define REG_ACCESS_MAP_SVH

// Index of each pin in the synchroniser bundle
`define SY_SCK        0
`define SY_SSN        1
`define SY_MOSI       2
`define SY_MDC        3
`define SY_MDIO       4
`define SY_FAST       5
`define SY_PADDR_LO   6
`define SY_PADDR_HI   8
`define SY_WIDTH      9
`define SY_RESET_VAL  9'h01_2

// Serial instruction layout
`define SPI_LAST_BIT  6'h37
`define SPI_DATA_BITS 6'h20
`define SPI_CMD_POS   55
`define SPI_CHAN_HI   54
`define SPI_CHAN_LO   53
`define SPI_DEV_HI    52
`define SPI_DEV_LO    48
`define SPI_REG_HI    47
`define SPI_REG_LO    32

// Management frame counts
`define MDIO_PRE_MIN   6'h20
`define MDIO_HDR_LAST  6'h0C
`define MDIO_TA_LAST   6'h01
`define MDIO_DATA_LAST 6'h0F
`define MDIO_OP_ADDR   2'h0
`define MDIO_OP_WRITE  2'h1
`define MDIO_OP_RDINC  2'h2
`define MDIO_OP_READ   2'h3

// Register groups by device number
`define DEV_LINE_PMA  5'h01
`define DEV_RATE_COMP 5'h04
`define DEV_LINE_KR   5'h07
`define DEV_HOST_PMA  5'h09
`define DEV_HOST_KR   5'h0F
`define DEV_GLOBAL    5'h1E

`endif

// file: hdl/reg_access_pkg.sv
// Types shared by the register access port logic.
// Assumes the map header supplies all numeric constants.
package reg_access_pkg;

  typedef enum logic [1:0] {
    MDIO_PRE  = 2'b00,
    MDIO_HDR  = 2'b01,
    MDIO_TA   = 2'b10,
    MDIO_DATA = 2'b11
  } mdio_state_t;

  typedef enum logic {
    SPI_CMD_READ  = 1'b0,
    SPI_CMD_WRITE = 1'b1
  } spi_cmd_t;

endpackage : reg_access_pkg

// file: hdl/pin_sync.sv
// Two-flop synchroniser with edge detection for a bundle of pins.
// Assumes pins are asynchronous to mclk and slow against it.
module pin_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] lvl,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] last_ff;

  // Only sync_ff reads meta_ff; edges are taken from the stable stages
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge mclk) begin
      if (!resetn) begin
        meta_ff[i] <= RST_VAL[i];
        sync_ff[i] <= RST_VAL[i];
        last_ff[i] <= RST_VAL[i];
      end else begin
        meta_ff[i] <= din[i];
        sync_ff[i] <= meta_ff[i];
        last_ff[i] <= sync_ff[i];
      end
    end
    assign lvl[i]  = sync_ff[i];
    assign rise[i] = sync_ff[i] & ~last_ff[i];
    assign fall[i] = ~sync_ff[i] & last_ff[i];
  end

endmodule : pin_sync

// file: dv/reg_access_ports_asserts.sv
// Port-level checks on the serial register access front end.
// Assumes mclk runs far faster than spi_sck and mdc, and a bind from the bench.
`include "reg_access_map.svh"
module reg_access_ports_asserts (
  input wire logic       mclk,
  input wire logic       resetn,
  input wire logic       spi_sck,
  input wire logic       spi_ssn_n,
  input wire logic       spi_fast_mode,
  input wire logic       spi_miso,
  input wire logic       spi_miso_oe,
  input wire logic       mdc,
  input wire logic       mdio_oe,
  input wire logic       reg_req,
  input wire logic [4:0] reg_dev
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  a_miso_released: assert property (spi_ssn_n [*4] |-> !spi_miso_oe)
    else $error("miso driven while deselected");
  a_miso_driven: assert property (!spi_ssn_n [*4] |-> spi_miso_oe)
    else $error("miso not driven while selected");
  a_req_one_pulse: assert property (reg_req |=> !reg_req)
    else $error("request longer than one cycle");
  a_req_known_dev: assert property (reg_req |-> reg_dev inside {`DEV_LINE_PMA,
    `DEV_RATE_COMP, `DEV_LINE_KR, `DEV_HOST_PMA, `DEV_HOST_KR, `DEV_GLOBAL})
    else $error("request to an unknown device number");
  // A request needs a select held low or a management clock rise behind it
  a_req_has_cause: assert property (reg_req |-> !$past(spi_ssn_n, 4) ||
    $past(mdc, 3) || $past(mdc, 4))
    else $error("request without a live port");
  a_miso_on_fall: assert property ($changed(spi_miso) && $past(spi_miso_oe) &&
    !spi_ssn_n && !$past(spi_fast_mode, 5) |-> !$past(spi_sck, 1))
    else $error("miso moved while clock high in default mode");
  a_miso_on_rise: assert property ($changed(spi_miso) && $past(spi_miso_oe) &&
    !spi_ssn_n && spi_fast_mode && $past(spi_fast_mode, 5) |-> $past(spi_sck, 1))
    else $error("miso moved while clock low in fast mode");
  a_mdio_drive_start: assert property ($rose(mdio_oe) |-> mdc && $past(mdc, 1))
    else $error("management drive started away from a clock rise");
  a_mdio_drive_holds: assert property ($rose(mdio_oe) |=> mdio_oe [*8])
    else $error("management drive dropped early");
endmodule : reg_access_ports_asserts

// file: dv/mgmt_host_model.sv
// Behavioural SPI master and clause-45 management host.
// Assumes the bench resolves miso_line and mdio_line and calls these tasks in turn.
module mgmt_host_model (
  input  wire logic mclk,
  input  wire logic miso_line,
  input  wire logic mdio_line,
  output logic      sck,
  output logic      ssn_n,
  output logic      mosi,
  output logic      mdc,
  output logic      mdio_drv,
  output logic      mdio_drv_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // Both link clocks stand still low between frames
  initial begin
    sck = 1'h0;
    ssn_n = 1'h1;
    mosi = 1'h0;
    mdc = 1'h0;
    mdio_drv = 1'h1;
    mdio_drv_oe = 1'h0;
  end

  task automatic w(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : w

  // Shifts nb bits from bit 55 down; miso is taken at each rise
  task automatic spi_xfer(input logic [55:0] tx, input int nb, output logic [55:0] rx);
    rx = 56'h0;
    if (ssn_n) begin
      ssn_n = 1'h0;
      w(10);
    end
    for (int i = 55; i > 55 - nb; i--) begin
      mosi = tx[i];
      w(10);
      sck = 1'h1;
      rx[i] = miso_line;
      w(10);
      sck = 1'h0;
    end
  endtask : spi_xfer

  task automatic spi_end();
    w(10);
    ssn_n = 1'h1;
    mosi = ~mosi;
    w(10);
  endtask : spi_end

  // 25 mclk half period: 2.5 Mbps
  task automatic mclk_bit(input logic b, input logic oe, output logic s);
    mdio_drv = b;
    mdio_drv_oe = oe;
    w(25);
    mdc = 1'h1;
    s = mdio_line;
    w(25);
    mdc = 1'h0;
  endtask : mclk_bit

  task automatic mdio_frame(input logic [1:0] op, input logic [4:0] pa, input logic [15:0] d,
                            output logic [15:0] rd);
    logic [45:0] hdr;
    logic [17:0] tail;
    logic        s;
    hdr = {32'hFFFF_FFFF, 2'h0, op, pa, 5'h01};
    tail = {2'h2, d};
    rd = 16'h0;
    for (int i = 45; i >= 0; i--) mclk_bit(hdr[i], 1'h1, s);
    for (int j = 0; j < 18; j++) begin
      mclk_bit(tail[17 - j], !op[1], s);
      if (j >= 2) rd[17 - j] = s;
    end
    mdio_drv_oe = 1'h0;
  endtask : mdio_frame
endmodule : mgmt_host_model

// file: dv/register_access_serial_ports_tb.sv
// Self-checking bench for the serial register access front end.
// Assumes the host model drives the pins and a small register space answers here.
`include "reg_access_map.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module register_access_serial_ports_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [22:0] A = {2'h1, 5'h01, 16'h0010};
  localparam logic [22:0] B = {2'h3, 5'h1E, 16'hDEAD};
  localparam logic [22:0] E = {2'h0, 5'h02, 16'h0001};
  localparam logic [22:0] C = {2'h2, 5'h09, 16'h0200};
  localparam logic [22:0] C2 = {2'h0, 5'h07, 16'h0033};
  localparam logic [22:0] M = {2'h2, 5'h01, 16'h0040};
  localparam logic [31:0] D1 = 32'hA5C3_0F1E;
  localparam logic [31:0] D2 = 32'h1357_9BDF;
  localparam logic [31:0] D3 = 32'h8001_7FFE;
  localparam logic [31:0] ONES = 32'hFFFF_FFFF;
  localparam logic [4:0] PA = {3'h5, 2'h2};
  logic        mclk;
  logic        resetn;
  logic        spi_fast_mode;
  logic        reg_ack;
  logic        reg_hit;
  logic [31:0] reg_rdata;
  logic        rd_pend;
  logic [22:0] rd_a;
  logic [31:0] mem [logic [22:0]];
  int          n_fail = 0;
  int          samples_checked = 0;
  int          n_req = 0;
  wire logic   sck, ssn_n, mosi, mdc, mdio_drv, mdio_drv_oe, miso_line, mdio_line;
  wire logic   spi_miso, spi_miso_oe, mdio_out, mdio_oe, reg_req, reg_we;
  wire logic [1:0]  reg_chan;
  wire logic [4:0]  reg_dev;
  wire logic [15:0] reg_num;
  wire logic [31:0] reg_wdata;

  assign miso_line = spi_miso_oe ? spi_miso : 1'hz;
  // The management line has a pull-up when nobody drives it
  assign mdio_line = mdio_oe ? mdio_out : mdio_drv_oe ? mdio_drv : 1'h1;

  reg_access_ports dut (.mclk(mclk), .resetn(resetn), .spi_sck(sck), .spi_ssn_n(ssn_n),
    .spi_mosi(mosi), .spi_fast_mode(spi_fast_mode), .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe), .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out),
    .mdio_oe(mdio_oe), .port_addr_strap(3'h5), .reg_req(reg_req), .reg_we(reg_we),
    .reg_chan(reg_chan), .reg_dev(reg_dev), .reg_num(reg_num), .reg_wdata(reg_wdata),
    .reg_ack(reg_ack), .reg_hit(reg_hit), .reg_rdata(reg_rdata));

  mgmt_host_model host (.mclk(mclk), .miso_line(miso_line), .mdio_line(mdio_line),
    .sck(sck), .ssn_n(ssn_n), .mosi(mosi), .mdc(mdc), .mdio_drv(mdio_drv),
    .mdio_drv_oe(mdio_drv_oe));

  // Reads answer one cycle late; register 16'hDEAD is unmapped and returns junk
  always @(posedge mclk) begin
    #1;
    reg_ack = 1'h0;
    if (rd_pend) begin
      reg_ack = 1'h1;
      reg_hit = rd_a[15:0] !== 16'hDEAD;
      reg_rdata = !reg_hit ? ONES : mem.exists(rd_a) ? mem[rd_a] : 32'h0;
      rd_pend = 1'h0;
    end
    if (reg_req === 1'h1) begin
      n_req++;
      if (reg_we) mem[{reg_chan, reg_dev, reg_num}] = reg_wdata;
      else begin
        rd_pend = 1'h1;
        rd_a = {reg_chan, reg_dev, reg_num};
      end
    end
  end

  task automatic t_spi_pipeline;
    logic [55:0] tx [6];
    logic [55:0] ex [6];
    logic [55:0] rx;
    int          r0;
    // Read data fields carry ones, to be discarded
    tx = '{{1'h1, A, D1}, {1'h0, A, ONES}, {1'h0, B, ONES}, {1'h0, E, ONES},
           {1'h0, A, ONES}, {1'h1, C, D2}};
    ex = '{56'h0, {1'h1, A, D1}, {1'h0, A, D1}, {1'h0, B, 32'h0}, {1'h0, E, 32'h0},
           {1'h0, A, 32'h0}};
    r0 = n_req;
    foreach (tx[i]) begin
      host.spi_xfer(tx[i], 56, rx);
      `CHK("spi_miso", ex[i], rx)
    end
    host.spi_end();
    `CHK("spi_request_count", 5, n_req - r0)
    `CHK("spi_write_data", D1, mem[A])
  endtask : t_spi_pipeline

  task automatic t_spi_abort;
    logic [55:0] rx;
    int          r0;
    r0 = n_req;
    host.spi_xfer({1'h1, C2, D3}, 20, rx);
    host.spi_end();
    `CHK("partial_request_count", 0, n_req - r0)
    host.spi_xfer({1'h1, C2, D3}, 56, rx);
    host.spi_end();
    `CHK("spi_miso", {1'h1, C, D2}, rx)
    `CHK("spi_write_data", D3, mem[C2])
  endtask : t_spi_abort

  task automatic t_spi_fast;
    logic [55:0] rx;
    spi_fast_mode = 1'h1;
    host.w(10);
    host.spi_xfer({1'h0, C2, ONES}, 56, rx);
    `CHK("fast_miso", {1'h1, C2, D3}, rx)
    host.spi_xfer({1'h0, A, ONES}, 56, rx);
    `CHK("fast_miso", {1'h0, C2, D3}, rx)
    host.spi_end();
    spi_fast_mode = 1'h0;
  endtask : t_spi_fast

  task automatic t_mdio;
    logic [15:0] rd;
    int          r0;
    // Upper half first; all four frames per wide write
    host.mdio_frame(`MDIO_OP_ADDR, PA, 16'h0081, rd);
    host.mdio_frame(`MDIO_OP_WRITE, PA, 16'h1234, rd);
    host.mdio_frame(`MDIO_OP_ADDR, PA, 16'h0080, rd);
    host.mdio_frame(`MDIO_OP_WRITE, PA, 16'h5678, rd);
    `CHK("mdio_write_word", 32'h1234_5678, mem[M])
    host.mdio_frame(`MDIO_OP_ADDR, PA, 16'h0080, rd);
    host.mdio_frame(`MDIO_OP_RDINC, PA, 16'h0, rd);
    `CHK("mdio_lower_half", 16'h5678, rd)
    host.mdio_frame(`MDIO_OP_READ, PA, 16'h0, rd);
    `CHK("mdio_upper_half", 16'h1234, rd)
    r0 = n_req;
    host.mdio_frame(`MDIO_OP_READ, {3'h3, 2'h2}, 16'h0, rd);
    `CHK("foreign_port_data", 16'hFFFF, rd)
    `CHK("foreign_port_requests", 0, n_req - r0)
  endtask : t_mdio

  task automatic results;
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results

  initial begin
    mclk = 1'h0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    resetn = 1'h0;
    spi_fast_mode = 1'h0;
    reg_ack = 1'h0;
    reg_hit = 1'h0;
    reg_rdata = 32'h0;
    rd_pend = 1'h0;
    repeat (3) @(posedge mclk);
    #1;
    resetn = 1'h1;
    host.w(3);
    t_spi_pipeline();
    t_spi_abort();
    t_spi_fast();
    // One port at a time; no arbitration
    t_mdio();
    results();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    results();
  end
endmodule : register_access_serial_ports_tb

bind reg_access_ports reg_access_ports_asserts u_chk (.mclk(mclk), .resetn(resetn),
  .spi_sck(spi_sck), .spi_ssn_n(spi_ssn_n), .spi_fast_mode(spi_fast_mode),
  .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .mdc(mdc), .mdio_oe(mdio_oe),
  .reg_req(reg_req), .reg_dev(reg_dev));
